// File: logic/saah_top.sv
// saah_top: two-axis servo alarm handler, gating power-stage drive.
// assumes all inputs synchronous to MCLK_IN; clear commands arrive as
// one-cycle pulses decoded from the network link.
//
// Functional notes
// - Any alarm cuts the affected power-stage drive at once so the motor coasts.
// - All-axis alarms stop both axes, each-axis alarms stop only their own axis.
// - An error-reset or CPU-reset command from the controller clears the alarm.
// - Removing and restoring control power clears a latched alarm.
// - Any clear is refused while the alarm's cause is still present.
// - Undervoltage is raised when control power returns after more than 60 ms lost.
// - Undervoltage is raised when bus voltage is at or below 200 V with servo on.
module saah_top
  import saah_pkg::*;
#(
  parameter int unsigned LOSS_CYC = saah_pkg::PWR_LOSS_CYC
) (
  input  wire logic        MCLK_IN,
  input  wire logic        RESET_IN,
  input  wire saah_cause_t CAUSE_A_IN,
  input  wire saah_cause_t CAUSE_B_IN,
  input  wire saah_clr_t   CLR_CMD_IN,
  input  wire logic        CTRL_PWR_OK_IN,
  input  wire logic [11:0] BUS_VOLTS_IN,
  input  wire logic [1:0]  SERVO_ON_IN,
  output logic [1:0]       DRV_EN_OUT,
  output logic [1:0]       ALARM_OUT,
  output logic             UNDERVOLT_OUT,
  output logic             MAIN_PWR_OFF_OUT
);
  import saah_pkg::*;

  // counter just wide enough for the loss span
  localparam int unsigned CW = $clog2(LOSS_CYC + 1);

  // supervisor state, loss timing and per-axis cause vectors
  saah_ps_t       ps_r;
  saah_ps_t       ps_nxt;
  logic [CW-1:0]  loss_cnt_r;
  logic           uv_pwr_r;
  logic           pwr_ok_d_r;
  logic           pwr_restore;
  logic           uv_bus;
  logic           clear_req;
  logic [NUM_CAUSES-1:0] all_stop;
  logic [NUM_CAUSES-1:0] cause_a;
  logic [NUM_CAUSES-1:0] cause_b;
  logic [NUM_CAUSES-1:0] lat_a;
  logic [NUM_CAUSES-1:0] lat_b;
  logic [1:0]     drv_en;

  ////////////////////////////////////////////////////////////////////////
  // control supply supervisor: counts loss time while power is absent
  // the loss time is counted in PS_LOST; reaching PS_LONG arms the
  // undervoltage pulse, which fires on the edge where supply returns.
  // a short dip goes back to PS_UP and raises nothing, but its return
  // edge still acts as a power-cycle clear of the latched alarms.
  // rising edge of the supply flag marks a control power cycle
  assign pwr_restore = CTRL_PWR_OK_IN & ~pwr_ok_d_r;

  // next state: any return of supply goes back to PS_UP
  always_comb begin
    ps_nxt = ps_r;
    unique case (ps_r)
      PS_UP:   if (!CTRL_PWR_OK_IN) ps_nxt = PS_LOST;
      PS_LOST: if (CTRL_PWR_OK_IN) ps_nxt = PS_UP;
               else if (loss_cnt_r >= CW'(LOSS_CYC - 1)) ps_nxt = PS_LONG;
      PS_LONG: if (CTRL_PWR_OK_IN) ps_nxt = PS_UP;
      default: ps_nxt = PS_UP;
    endcase
  end

  // loss counter and one-cycle undervoltage pulse from long loss
  // counter runs only while lost, so it restarts on every dip
  always_ff @(posedge MCLK_IN) begin
    if (RESET_IN) begin
      ps_r       <= PS_UP;
      loss_cnt_r <= '0;
      pwr_ok_d_r <= 1'b1;
      uv_pwr_r   <= 1'b0;
    end else begin
      ps_r       <= ps_nxt;
      pwr_ok_d_r <= CTRL_PWR_OK_IN;
      loss_cnt_r <= (ps_r == PS_LOST) ? loss_cnt_r + CW'(1) : '0;
      if (ps_r == PS_LONG && CTRL_PWR_OK_IN) uv_pwr_r <= 1'b1;
      else if (ps_r == PS_UP)                uv_pwr_r <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // bus undervoltage with servo on
  assign uv_bus = (|SERVO_ON_IN) && (BUS_VOLTS_IN <= BUS_UV_VOLTS);

  // clears are levels: every high cycle is one attempt, so a held command
  // keeps clearing bits whose cause has gone
  // command clear; control power cycle clear
  assign clear_req = CLR_CMD_IN.err_reset | CLR_CMD_IN.cpu_reset | pwr_restore;

  // undervoltage rides on bit 0 of the all-axis group; a cause source
  // wired to that bit reads back as undervoltage too
  // all-axis causes feed both axes, undervoltage is all-axis
  assign all_stop = CAUSE_A_IN.all_stop | CAUSE_B_IN.all_stop
                  | {{(NUM_CAUSES-1){1'b0}}, (uv_pwr_r | uv_bus)};
  assign cause_a  = all_stop | CAUSE_A_IN.each_stop;
  assign cause_b  = all_stop | CAUSE_B_IN.each_stop;

  ////////////////////////////////////////////////////////////////////////
  // both axes share the clear request: a command always targets every axis
  // one latch and drive gate per axis
  saah_axis #(.N(NUM_CAUSES)) u_axis_a (
    .clk_in      (MCLK_IN),
    .rst_in      (RESET_IN),
    .cause_in    (cause_a),
    .clear_in    (clear_req),
    .run_in      (SERVO_ON_IN[0]),
    .latched_out (lat_a),
    .drv_en_out  (drv_en[0])
  );

  saah_axis #(.N(NUM_CAUSES)) u_axis_b (
    .clk_in      (MCLK_IN),
    .rst_in      (RESET_IN),
    .cause_in    (cause_b),
    .clear_in    (clear_req),
    .run_in      (SERVO_ON_IN[1]),
    .latched_out (lat_b),
    .drv_en_out  (drv_en[1])
  );

  ////////////////////////////////////////////////////////////////////////
  // main power off follows the latches, not the live causes, so it
  // stays asserted until the alarm is really cleared; undervoltage reads
  // the axis a latch, so it clears together with that alarm
  // status to the outside sequence
  // request main power off on any alarm
  // both axes alarmed also lands here
  assign DRV_EN_OUT       = drv_en;
  assign ALARM_OUT        = {|lat_b, |lat_a};
  assign UNDERVOLT_OUT    = lat_a[0];
  assign MAIN_PWR_OFF_OUT = |lat_a | |lat_b;

  ////////////////////////////////////////////////////////////////////////
  // all-axis drive cut
  all_axis_a: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    (|all_stop) |-> DRV_EN_OUT == 2'b00)
    else $error("all-axis alarm left a drive on");

  each_axis_a: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    (|CAUSE_A_IN.each_stop) |=> ALARM_OUT[0])
    else $error("each-axis alarm not latched");

  own_axis_a: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    (|CAUSE_B_IN.each_stop && !(|cause_a) && !ALARM_OUT[0]) |=> !ALARM_OUT[0])
    else $error("each-axis alarm spread to other axis");

  drive_b_cut_a: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    (|cause_b) |-> !DRV_EN_OUT[1])
    else $error("axis b drive on during cause");

  bus_uv_a: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    uv_bus |=> UNDERVOLT_OUT)
    else $error("bus undervoltage missed");

  supply_lost_a: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    (ps_r == PS_UP && !CTRL_PWR_OK_IN) |=> (ps_r == PS_LOST))
    else $error("supply loss not tracked");

  long_count_a: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    (ps_r == PS_LOST && !CTRL_PWR_OK_IN && loss_cnt_r == CW'(LOSS_CYC - 1))
    |=> (ps_r == PS_LONG))
    else $error("loss span not reached");

  long_loss_a: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    (ps_r == PS_LONG && CTRL_PWR_OK_IN) |=> ##1 UNDERVOLT_OUT)
    else $error("long power loss missed");

  uv_pulse_a: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    uv_pwr_r |=> !uv_pwr_r)
    else $error("undervoltage pulse stuck");

  short_loss_a: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    (ps_r == PS_LOST && CTRL_PWR_OK_IN) |=> !uv_pwr_r)
    else $error("short loss raised undervoltage");

  cmd_clear_a: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    (CLR_CMD_IN.err_reset && !(|cause_a)) |=> !ALARM_OUT[0])
    else $error("clear command ignored");

  clear_refused_a: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    (clear_req && (|cause_a)) |=> ALARM_OUT[0])
    else $error("clear taken while cause present");

  pwr_clear_a: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    (pwr_restore && !(|cause_b)) |=> !ALARM_OUT[1])
    else $error("power cycle did not clear");

  restore_clear_a: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    (pwr_restore && !(|cause_a)) |=> !ALARM_OUT[0])
    else $error("power cycle did not clear axis a");

  main_off_a: assert property (@(posedge MCLK_IN) disable iff (RESET_IN)
    ((|cause_a) || (|cause_b)) |=> MAIN_PWR_OFF_OUT)
    else $error("main power off not requested");

endmodule : saah_top

// File: common/saah_pkg.sv
// saah_pkg: shared types and constants for the two-axis alarm handler.
// assumes a 10 MHz single clock and synchronous active-high reset.
package saah_pkg;

  // clock rate and power-loss time
  localparam int unsigned CLK_HZ          = 10_000_000;
  localparam int unsigned PWR_LOSS_MS     = 60;
  // cycles per ms truncate, exact at 10 MHz: 60 ms -> 600000 cycles
  localparam int unsigned PWR_LOSS_CYC    = (PWR_LOSS_MS * (CLK_HZ / 1000));
  // bus threshold in volts, compared against the measured code
  localparam logic [11:0] BUS_UV_VOLTS    = 12'h0C8;
  localparam int unsigned NUM_CAUSES      = 8;
  // reset values
  localparam logic [7:0]  ALARM_RST       = 8'h00;
  localparam logic        DRV_EN_RST      = 1'b0;

  // per-axis alarm cause bundle
  typedef struct packed {
    logic [NUM_CAUSES-1:0] all_stop;   // causes that stop both axes
    logic [NUM_CAUSES-1:0] each_stop;  // causes that stop this axis only
  } saah_cause_t;

  // clear requests from the controller side
  typedef struct packed {
    logic err_reset;
    logic cpu_reset;
  } saah_clr_t;

  // control supply supervisor states
  typedef enum logic [1:0] {
    PS_UP   = 2'b00,
    PS_LOST = 2'b01,
    PS_LONG = 2'b11
  } saah_ps_t;

endpackage : saah_pkg

// File: logic/saah_axis.sv
// saah_axis: alarm latch and drive gate for one axis.
// assumes causes are levels that stay high while the fault persists.
module saah_axis
  import saah_pkg::*;
#(
  parameter int unsigned N = saah_pkg::NUM_CAUSES
) (
  input  wire logic         clk_in,
  input  wire logic         rst_in,
  input  wire logic [N-1:0] cause_in,
  input  wire logic         clear_in,
  input  wire logic         run_in,
  output logic [N-1:0]      latched_out,
  output logic              drv_en_out
);

  logic [N-1:0] alarm_r;
  logic [N-1:0] alarm_nxt;
  logic         drv_r;

  ////////////////////////////////////////////////////////////////////////
  // latch: set wins over clear, so a live cause is never dropped
  // clear refused while cause present
  assign alarm_nxt   = cause_in | (clear_in ? {N{1'b0}} : alarm_r);
  assign latched_out = alarm_r;

  // registered gate; cut combinationally too so shutdown is immediate
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      alarm_r <= {N{1'b0}};
      drv_r   <= DRV_EN_RST;
    end else begin
      alarm_r <= alarm_nxt;
      drv_r   <= run_in & ~|alarm_nxt;
    end
  end

  assign drv_en_out = drv_r & ~|cause_in & ~|alarm_r;

  ////////////////////////////////////////////////////////////////////////
  // live cause latches
  cause_holds_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (|cause_in) |=> ((alarm_r & $past(cause_in)) == $past(cause_in)))
    else $error("cause did not latch");

  drive_off_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (|alarm_r) |-> !drv_en_out)
    else $error("drive on while alarmed");

  cause_cuts_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (|cause_in) |-> !drv_en_out)
    else $error("drive on during cause");

endmodule : saah_axis

// File: tb/saah_ctrl_model.sv
// saah_ctrl_model: controller side that sends error-reset and cpu-reset.
// assumes the bench raises req_in for one cycle per command wanted.
module saah_ctrl_model
  import saah_pkg::*;
(
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  input  wire logic [1:0] req_in,
  input  wire logic       main_off_in,
  output saah_clr_t       clr_out,
  output logic            main_on_out
);
  timeunit 1ns;
  timeprecision 1ps;
  ////////////////////////////////////////////////////////////////////////////
  // clear command issue
  // registered so a command lands whole on one clock, like a decoded frame
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      clr_out <= '0;
    end else begin
      clr_out <= '{err_reset: req_in[1], cpu_reset: req_in[0]};
    end
  end
  ////////////////////////////////////////////////////////////////////////////
  // main supply switched off
  // covers both axes alarmed
  // outside sequence opens the main contactor one clock after the request
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      main_on_out <= 1'b1;
    end else begin
      main_on_out <= ~main_off_in;
    end
  end
endmodule : saah_ctrl_model

// File: tb/tb_top.sv
// tb_top: self-checking bench for the two-axis alarm handler.
// assumes the controller model beside it and a 100 ns clock.
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import saah_pkg::*;
  localparam int unsigned LOSS = 20;  // short power-loss span keeps the run brief
  logic        clk, rst, pwr_ok, uv, mpo, main_on;
  saah_cause_t ca, cb;
  saah_clr_t   clr;
  logic [11:0] volts;
  logic [1:0]  servo, drv, alm, req;
  int          miscompares, samples_checked;
  ////////////////////////////////////////////////////////////////////////////
  saah_top #(.LOSS_CYC(LOSS)) u_saah_top (.MCLK_IN(clk), .RESET_IN(rst), .CAUSE_A_IN(ca),
    .CAUSE_B_IN(cb), .CLR_CMD_IN(clr), .CTRL_PWR_OK_IN(pwr_ok), .BUS_VOLTS_IN(volts),
    .SERVO_ON_IN(servo), .DRV_EN_OUT(drv), .ALARM_OUT(alm), .UNDERVOLT_OUT(uv),
    .MAIN_PWR_OFF_OUT(mpo));
  saah_ctrl_model u_saah_ctrl_model (.clk_in(clk), .rst_in(rst), .req_in(req),
    .main_off_in(mpo), .clr_out(clr), .main_on_out(main_on));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  ////////////////////////////////////////////////////////////////////////////
  // inputs always move a fixed 10 ns after the edge, clear of sampling
  task step;
    @(posedge clk);
    #10;
  endtask : step
  task chk(input logic [7:0] got, input logic [7:0] exp);
    samples_checked++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // one command: model registers it, design takes it on the next edge
  task clear_cmd(input logic [1:0] kind);
    req = kind;
    step;
    req = 2'b00;
    step;
  endtask : clear_cmd
  task t_each;
    ca.each_stop[3] = 1'b1;
    #1 chk(drv, 8'h02);
    step;
    chk({mpo, alm}, 8'h05);
    clear_cmd(2'b10);
    chk(alm, 8'h01);
    chk(main_on, 8'h00);
    ca.each_stop = '0;
    step;
    chk(drv, 8'h02);
    clear_cmd(2'b10);
    chk({mpo, alm}, 8'h00);
    step;
    chk(drv, 8'h03);
    $display("test each_axis done");
  endtask : t_each
  task t_all;
    cb.all_stop[2] = 1'b1;
    #1 chk(drv, 8'h00);
    step;
    chk({mpo, alm}, 8'h07);
    step;
    chk({main_on, alm}, 8'h03);
    cb.all_stop = '0;
    clear_cmd(2'b01);
    chk(alm, 8'h00);
    step;
    chk({main_on, drv}, 8'h07);
    $display("test all_axis done");
  endtask : t_all
  task t_pcycle;
    cb.each_stop[1] = 1'b1;
    step;
    cb.each_stop = '0;
    step;
    chk(alm, 8'h02);
    pwr_ok = 1'b0;
    repeat (2) step;
    pwr_ok = 1'b1;
    repeat (3) step;
    chk({uv, alm}, 8'h00);
    $display("test power_cycle done");
  endtask : t_pcycle
  task t_uvpwr;
    pwr_ok = 1'b0;
    repeat (LOSS + 2) step;
    pwr_ok = 1'b1;
    repeat (3) step;
    chk({uv, alm}, 8'h07);
    repeat (2) step;
    clear_cmd(2'b10);
    chk({uv, alm}, 8'h00);
    step;
    $display("test uv_power done");
  endtask : t_uvpwr
  task t_bus;
    volts = 12'h0C9;
    repeat (2) step;
    chk(uv, 8'h00);
    servo = 2'b00;
    volts = 12'h0C8;
    repeat (2) step;
    chk(uv, 8'h00);
    servo = 2'b11;
    repeat (2) step;
    chk({uv, alm}, 8'h07);
    volts = 12'h12C;
    clear_cmd(2'b01);
    chk(uv, 8'h00);
    $display("test uv_bus done");
  endtask : t_bus
  ////////////////////////////////////////////////////////////////////////////
  task end_of_test;
    $display("checks=%0d mismatches=%0d", samples_checked, miscompares);
    if (miscompares == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : end_of_test
  // watchdog: tests need about 7 us, so 200 us means a hang
  initial begin
    #200us;
    miscompares++;
    end_of_test;
  end
  initial begin
    {miscompares, samples_checked} = '0;
    {ca, cb, req} = '0;
    {rst, pwr_ok, servo} = 4'hF;
    volts = 12'h12C;
    repeat (10) step;
    chk({mpo, uv, alm, drv}, 8'h00);
    rst = 1'b0;
    repeat (2) step;
    chk(drv, 8'h03);
    t_each;
    t_all;
    t_pcycle;
    t_uvpwr;
    t_bus;
    end_of_test;
  end
endmodule : tb_top
